// file: rtl/mcd_clkdiv.v
// processor clock generator from the master clock
// assumes range bits and divider code are static-ish same-clock levels
`include "mcd_map.vh"

module mcd_clkdiv #(
  parameter BASE_HIGH = 2,
  parameter BASE_MID  = 3,
  parameter BASE_LOW  = 4
) (
  input  wire       clk,
  input  wire       arst_n,
  input  wire       master_clk_range_high,
  input  wire       master_clk_range_mid,
  input  wire [2:0] cpu_clock_divider,
  output reg        processor_clock,
  output reg        processor_tick
);

  reg  [8:0] count;
  wire [2:0] code;
  wire [8:0] base;
  wire [8:0] period;

  // ===========================================
  // period selection
  // code 111 behaves as 110, each step halves the rate
  assign code   = (cpu_clock_divider > `MCD_DIV_SAT) ? `MCD_DIV_SAT
                                                    : cpu_clock_divider;
  assign base   = master_clk_range_high ? BASE_HIGH[8:0] :
                  master_clk_range_mid  ? BASE_MID[8:0]  :
                                          BASE_LOW[8:0];
  assign period = base << code;

  // ===========================================
  // counter, tick at wrap and level clock high for first half
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count           <= 9'h000;
      processor_clock <= 1'b0;
      processor_tick  <= 1'b0;
    end else begin
      if (count >= period - 9'h001) begin
        count          <= 9'h000;
        processor_tick <= 1'b1;
      end else begin
        count          <= count + 9'h001;
        processor_tick <= 1'b0;
      end
      processor_clock <= (count < (period >> 1));
    end
  end

endmodule

// file: rtl/mcd_map.vh
// constants for the processor clock and memory decode block
// assumes inclusion by bare name from the rtl/ files of this block
`ifndef MCD_MAP_VH
`define MCD_MAP_VH

// ===========================================
// special function register addresses
`define MCD_SFR_BASE      8'h80
`define MCD_SFR_DPL0      8'h82
`define MCD_SFR_DPH0      8'h83
`define MCD_SFR_DPL1      8'h84
`define MCD_SFR_DPH1      8'h85
`define MCD_SFR_PTRSEL    8'h92
`define MCD_SFR_BANK      8'hB6
`define MCD_SFR_PAGE      8'hBF
`define MCD_SFR_PSW       8'hD0

// ===========================================
// field positions and reset values
`define MCD_PSW_BANK_LSB  3
`define MCD_PSW_BANK_MSB  4
`define MCD_PTRSEL_BIT    0
`define MCD_RST_BYTE      8'h00
`define MCD_RST_WORD      16'h0000
`define MCD_RST_BANK      3'h0

// ===========================================
// program space
`define MCD_RESET_VECTOR  16'h0000
`define MCD_VEC_FIRST     16'h0003
`define MCD_VEC_STEP_LOG2 3

// ===========================================
// external data space ranges
`define MCD_SHARED_DATA_RAM_LAST     16'h0FFF
`define MCD_CFG_FIRST     16'h2000
`define MCD_CFG_LAST      16'h20FF
`define MCD_BAT_FIRST     16'h20C0
`define MCD_BAT_LAST      16'h20C7
`define MCD_ADC_WORDS     16

// ===========================================
// internal data memory layout and clock divider
`define MCD_BIT_BYTE_BASE 8'h20
`define MCD_DIV_SAT       3'h6

`endif

// file: rtl/mcd_top.v
// memory decode around the 8-bit processor core: program window,
// internal data memory, special registers, external data space
// assumes all core-side requests come from logic on clk
`include "mcd_map.vh"

// Function
// - processor clock from range bits and 3-bit divider; 111 equals 110
// - 64 KB program space serves fetches and code constant loads
// - program accesses above lower 32 KB use 3-bit bank register
// - after reset fetching starts at program address zero
// - interrupt vectors start at 0x0003, spaced eight bytes apart
// - external data 4 KB RAM at zero shared with compute engine
// - nonzero frame divider lets ADC write first 0x40 shared bytes
// - external data moves only on register-indirect or pointer moves
// - only listed ranges respond; configuration and battery areas mapped
// - indirect external moves use R0 or R1 low and page register high
// - pointer external moves use selected 16-bit data pointer
// - select bit zero picks primary pointer, one picks secondary
// - select change keeps pointers; pointer operations use selected one
// - internal data memory is 256 bytes with one-byte address
// - direct upper half reaches registers, indirect reaches upper RAM
// - lowest 32 bytes are four register banks chosen by status bits
// - bytes 0x20 to 0x2F hold bit addresses 0x00 to 0x7F
// - lower 128 bytes reachable by direct and indirect addressing
// - fetch overlaps execution; one-cycle single-byte instructions
// - byte write to 32-bit shared RAM is read then write
// - unimplemented registers read zero, writes ignored
module mcd_top #(
  parameter BASE_HIGH = 2,
  parameter BASE_MID  = 3,
  parameter BASE_LOW  = 4
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        master_clk_range_high,
  input  wire        master_clk_range_mid,
  input  wire [2:0]  cpu_clock_divider,
  output wire        processor_clock,
  output wire        processor_tick,
  input  wire        prog_req,
  input  wire [15:0] prog_addr,
  output reg         flash_req,
  output reg  [17:0] flash_addr,
  output wire [15:0] reset_vector,
  input  wire [2:0]  irq_index,
  output wire [15:0] irq_vector,
  input  wire        mem_req,
  input  wire        mem_we,
  input  wire        mem_indirect,
  input  wire [7:0]  mem_addr,
  input  wire [7:0]  mem_wdata,
  output reg  [7:0]  mem_rdata,
  input  wire [2:0]  reg_sel,
  output wire [7:0]  reg_addr,
  input  wire        bit_we,
  input  wire [6:0]  bit_addr,
  input  wire        bit_wdata,
  output reg         bit_rdata,
  input  wire        dptr_load,
  input  wire        dptr_inc,
  input  wire [15:0] dptr_wdata,
  output wire [15:0] dptr_value,
  input  wire        movx_req,
  input  wire        movx_write,
  input  wire        movx_use_dptr,
  input  wire        movx_ri_sel,
  input  wire [7:0]  movx_wdata,
  output reg  [7:0]  movx_rdata,
  output reg         movx_done,
  input  wire [3:0]  adc_frame_divider,
  input  wire        adc_wr_req,
  input  wire [3:0]  adc_wr_word,
  input  wire [31:0] adc_wr_data,
  output wire        adc_wr_ack,
  output reg  [9:0]  ram_addr,
  output reg         ram_re,
  output reg         ram_we,
  output reg  [31:0] ram_wdata,
  input  wire [31:0] ram_rdata
);

  localparam S_IDLE  = 2'b00;
  localparam S_ISSUE = 2'b01;
  localparam S_DATA  = 2'b10;

  reg  [7:0]  iram [0:255];
  reg  [7:0]  cfg_ram [0:255];
  reg  [7:0]  bat_ram [0:7];
  reg  [15:0] dptr_primary;
  reg  [15:0] secondary_data_pointer;
  reg  [7:0]  pointer_select;
  reg  [2:0]  program_bank_select;
  reg  [7:0]  movx_page_high;
  reg  [7:0]  psw;
  reg  [7:0]  sfr_rd;
  reg  [1:0]  state;
  reg  [1:0]  x_lane;
  reg         x_write;
  reg  [7:0]  x_wdata;
  wire [1:0]  bank;
  wire        sfr_hit;
  wire        sfr_wr;
  wire [7:0]  ri_value;
  wire [15:0] movx_addr;
  wire        shared_hit;
  wire        bat_hit;
  wire        cfg_hit;
  wire        adc_take;
  wire        movx_start;
  wire [7:0]  bit_byte;

  // ===========================================
  // helpers
  // working register address from bank and register number
  function [7:0] reg_address;
    input [1:0] bk;
    input [2:0] rn;
    begin
      reg_address = {3'b000, bk, rn};
    end
  endfunction

  // byte replaced into a 32-bit word at the given lane
  function [31:0] merge_byte;
    input [31:0] word;
    input [1:0]  lane;
    input [7:0]  data;
    begin
      merge_byte = word;
      case (lane)
        2'd0: merge_byte[7:0]   = data;
        2'd1: merge_byte[15:8]  = data;
        2'd2: merge_byte[23:16] = data;
        default: merge_byte[31:24] = data;
      endcase
    end
  endfunction

  // byte picked from a 32-bit word
  function [7:0] pick_byte;
    input [31:0] word;
    input [1:0]  lane;
    begin
      pick_byte = word[{lane, 3'b000} +: 8];
    end
  endfunction

  // ===========================================
  // processor clock
  mcd_clkdiv #(
    .BASE_HIGH (BASE_HIGH),
    .BASE_MID  (BASE_MID),
    .BASE_LOW  (BASE_LOW)
  ) u_clkdiv (
    .clk                   (clk),
    .arst_n                (arst_n),
    .master_clk_range_high (master_clk_range_high),
    .master_clk_range_mid  (master_clk_range_mid),
    .cpu_clock_divider     (cpu_clock_divider),
    .processor_clock       (processor_clock),
    .processor_tick        (processor_tick)
  );

  // ===========================================
  // program space
  assign reset_vector = `MCD_RESET_VECTOR;
  assign irq_vector   = `MCD_VEC_FIRST +
                        ({13'h0000, irq_index} << `MCD_VEC_STEP_LOG2);

  // fetch and constant-load address, issued one cycle ahead of use
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_req  <= 1'b0;
      flash_addr <= 18'h00000;
    end else begin
      flash_req <= prog_req;
      if (prog_addr[15])
        flash_addr <= {program_bank_select, prog_addr[14:0]};
      else
        flash_addr <= {3'b000, prog_addr[14:0]};
    end
  end

  // ===========================================
  // internal data memory decode
  assign bank     = psw[`MCD_PSW_BANK_MSB:`MCD_PSW_BANK_LSB];
  assign reg_addr = reg_address(bank, reg_sel);
  assign sfr_hit  = ~mem_indirect & mem_addr[7];
  assign sfr_wr   = mem_req & mem_we & sfr_hit;
  assign bit_byte = `MCD_BIT_BYTE_BASE + {4'h0, bit_addr[6:3]};

  // byte writes, indirect upper half lands in upper RAM
  always @(posedge clk) begin
    if (mem_req & mem_we & ~sfr_hit)
      iram[mem_addr] <= mem_wdata;
    else if (bit_we)
      iram[bit_byte][bit_addr[2:0]] <= bit_wdata;
  end

  // special register read mux, unused addresses read zero
  always @* begin
    sfr_rd = `MCD_RST_BYTE;
    if (mem_addr == `MCD_SFR_DPL0)
      sfr_rd = dptr_primary[7:0];
    else if (mem_addr == `MCD_SFR_DPH0)
      sfr_rd = dptr_primary[15:8];
    else if (mem_addr == `MCD_SFR_DPL1)
      sfr_rd = secondary_data_pointer[7:0];
    else if (mem_addr == `MCD_SFR_DPH1)
      sfr_rd = secondary_data_pointer[15:8];
    else if (mem_addr == `MCD_SFR_PTRSEL)
      sfr_rd = pointer_select;
    else if (mem_addr == `MCD_SFR_BANK)
      sfr_rd = {5'b00000, program_bank_select};
    else if (mem_addr == `MCD_SFR_PAGE)
      sfr_rd = movx_page_high;
    else if (mem_addr == `MCD_SFR_PSW)
      sfr_rd = psw;
  end

  // registered read data for byte and bit ports
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_rdata <= `MCD_RST_BYTE;
      bit_rdata <= 1'b0;
    end else begin
      if (mem_req & ~mem_we)
        mem_rdata <= sfr_hit ? sfr_rd : iram[mem_addr];
      bit_rdata <= iram[bit_byte][bit_addr[2:0]];
    end
  end

  // ===========================================
  // special registers and data pointers
  assign dptr_value = pointer_select[`MCD_PTRSEL_BIT] ?
                      secondary_data_pointer : dptr_primary;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dptr_primary           <= `MCD_RST_WORD;
      secondary_data_pointer <= `MCD_RST_WORD;
      pointer_select         <= `MCD_RST_BYTE;
      program_bank_select    <= `MCD_RST_BANK;
      movx_page_high         <= `MCD_RST_BYTE;
      psw                    <= `MCD_RST_BYTE;
    end else begin
      // pointer operations touch only the selected pointer
      if (dptr_load) begin
        if (pointer_select[`MCD_PTRSEL_BIT])
          secondary_data_pointer <= dptr_wdata;
        else
          dptr_primary <= dptr_wdata;
      end else if (dptr_inc) begin
        if (pointer_select[`MCD_PTRSEL_BIT])
          secondary_data_pointer <= secondary_data_pointer + 16'h0001;
        else
          dptr_primary <= dptr_primary + 16'h0001;
      end
      // direct writes; unlisted addresses fall through untouched
      if (sfr_wr) begin
        if (mem_addr == `MCD_SFR_DPL0)
          dptr_primary[7:0] <= mem_wdata;
        else if (mem_addr == `MCD_SFR_DPH0)
          dptr_primary[15:8] <= mem_wdata;
        else if (mem_addr == `MCD_SFR_DPL1)
          secondary_data_pointer[7:0] <= mem_wdata;
        else if (mem_addr == `MCD_SFR_DPH1)
          secondary_data_pointer[15:8] <= mem_wdata;
        else if (mem_addr == `MCD_SFR_PTRSEL)
          pointer_select <= mem_wdata;
        else if (mem_addr == `MCD_SFR_BANK)
          program_bank_select <= mem_wdata[2:0];
        else if (mem_addr == `MCD_SFR_PAGE)
          movx_page_high <= mem_wdata;
        else if (mem_addr == `MCD_SFR_PSW)
          psw <= mem_wdata;
      end
    end
  end

  // ===========================================
  // external data address and range decode
  assign ri_value  = iram[reg_address(bank, {2'b00, movx_ri_sel})];
  assign movx_addr = movx_use_dptr ? dptr_value
                                   : {movx_page_high, ri_value};
  assign shared_hit = (movx_addr <= `MCD_SHARED_DATA_RAM_LAST);
  assign bat_hit    = (movx_addr >= `MCD_BAT_FIRST) &
                      (movx_addr <= `MCD_BAT_LAST);
  assign cfg_hit    = (movx_addr >= `MCD_CFG_FIRST) &
                      (movx_addr <= `MCD_CFG_LAST) & ~bat_hit;

  // adc frame writes only while the divider field is nonzero
  assign adc_take   = adc_wr_req & (adc_frame_divider != 4'h0) &
                      (state == S_IDLE);
  assign adc_wr_ack = adc_take;
  assign movx_start = movx_req & ~movx_done & ~adc_take &
                      (state == S_IDLE);

  // configuration and battery-backed bytes
  always @(posedge clk) begin
    if (movx_start & movx_write & cfg_hit)
      cfg_ram[movx_addr[7:0]] <= movx_wdata;
    if (movx_start & movx_write & bat_hit)
      bat_ram[movx_addr[2:0]] <= movx_wdata;
  end

  // ===========================================
  // shared RAM sequencer: adc words, byte reads, read-modify-write
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= S_IDLE;
      x_lane     <= 2'b00;
      x_write    <= 1'b0;
      x_wdata    <= `MCD_RST_BYTE;
      ram_addr   <= 10'h000;
      ram_re     <= 1'b0;
      ram_we     <= 1'b0;
      ram_wdata  <= 32'h00000000;
      movx_rdata <= `MCD_RST_BYTE;
      movx_done  <= 1'b0;
    end else begin
      ram_re    <= 1'b0;
      ram_we    <= 1'b0;
      movx_done <= 1'b0;
      case (state)
        S_IDLE: begin
          if (adc_take) begin
            ram_addr  <= {6'b000000, adc_wr_word};
            ram_wdata <= adc_wr_data;
            ram_we    <= 1'b1;
          end else if (movx_start) begin
            if (shared_hit) begin
              ram_addr <= movx_addr[11:2];
              ram_re   <= 1'b1;
              x_lane   <= movx_addr[1:0];
              x_write  <= movx_write;
              x_wdata  <= movx_wdata;
              state    <= S_ISSUE;
            end else begin
              movx_done <= 1'b1;
              if (cfg_hit)
                movx_rdata <= cfg_ram[movx_addr[7:0]];
              else if (bat_hit)
                movx_rdata <= bat_ram[movx_addr[2:0]];
              else
                movx_rdata <= `MCD_RST_BYTE;
            end
          end
        end
        S_ISSUE: begin
          state <= S_DATA;
        end
        S_DATA: begin
          // second access writes the merged word back
          if (x_write) begin
            ram_wdata <= merge_byte(ram_rdata, x_lane, x_wdata);
            ram_we    <= 1'b1;
          end else begin
            movx_rdata <= pick_byte(ram_rdata, x_lane);
          end
          movx_done <= 1'b1;
          state     <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// file: verif/mcd_ram_model.sv
// behavioural shared 32-bit data RAM on the far side of mcd_top
// assumes one clock, registered read of one cycle, no reset
module mcd_ram_model (
  input  logic        clk,
  input  logic [9:0]  ram_addr,
  input  logic        ram_re,
  input  logic        ram_we,
  input  logic [31:0] ram_wdata,
  output logic [31:0] ram_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:1023];

  // ===========================================
  // known fill so merged lanes are never unknown
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 32'hA5A50000 | i;
    end
    ram_rdata = 32'h00000000;
  end

  // read data shows one cycle, then turns to its inverse
  always @(posedge clk) begin
    if (ram_we) begin
      mem[ram_addr] <= ram_wdata;
    end
    if (ram_re) begin
      ram_rdata <= mem[ram_addr];
    end else begin
      ram_rdata <= ~ram_rdata;
    end
  end
endmodule

// file: verif/mcd_top_chk.sv
// port checker for mcd_top
// assumes bind onto mcd_top, one clock, async active-low reset
module mcd_top_chk #(
  parameter BASE_HIGH = 2,
  parameter BASE_MID  = 3,
  parameter BASE_LOW  = 4
) (
  input logic        clk,
  input logic        arst_n,
  input logic        prog_req,
  input logic [15:0] prog_addr,
  input logic        flash_req,
  input logic [17:0] flash_addr,
  input logic [2:0]  irq_index,
  input logic [15:0] irq_vector,
  input logic [2:0]  reg_sel,
  input logic [7:0]  reg_addr,
  input logic [3:0]  adc_frame_divider,
  input logic        adc_wr_ack,
  input logic [3:0]  adc_wr_word,
  input logic [31:0] adc_wr_data,
  input logic        ram_re,
  input logic        ram_we,
  input logic [9:0]  ram_addr,
  input logic [31:0] ram_wdata,
  input logic        movx_req,
  input logic        movx_done,
  input logic        processor_clock,
  input logic        processor_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ===========================================
  // program window, vectors and register address
  property p_flash_map;
    prog_req |=> flash_req && {1'b0, flash_addr[14:0]} ==
      ($past(prog_addr) & 16'h7FFF) &&
      ($past(prog_addr) >= 16'h8000 || flash_addr[17:15] == 3'h0);
  endproperty
  a_flash_map: assert property (p_flash_map) else $error("flash map");
  property p_irq_vec;
    irq_vector == 16'h0003 + {10'h000, irq_index, 3'h0};
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("irq vector");
  property p_reg_addr;
    reg_addr[2:0] == reg_sel && reg_addr[7:5] == 3'h0;
  endproperty
  a_reg_addr: assert property (p_reg_addr) else $error("reg addr");

  // ===========================================
  // shared RAM traffic
  property p_adc_gate;
    adc_frame_divider == 4'h0 |-> !adc_wr_ack;
  endproperty
  a_adc_gate: assert property (p_adc_gate) else $error("adc gate");
  property p_adc_write;
    adc_wr_ack |=> ram_we && ram_addr == {6'h00, $past(adc_wr_word)} &&
      ram_wdata == $past(adc_wr_data);
  endproperty
  a_adc_write: assert property (p_adc_write) else $error("adc write");
  property p_rmw;
    ram_re |-> ##2 movx_done;
  endproperty
  a_rmw: assert property (p_rmw) else $error("ram read to done");
  property p_we_cause;
    ram_we |-> movx_done || $past(adc_wr_ack);
  endproperty
  a_we_cause: assert property (p_we_cause) else $error("stray write");
  property p_done_bound;
    $rose(movx_req) |-> ##[1:12] movx_done;
  endproperty
  a_done_bound: assert property (p_done_bound) else $error("stall");
  property p_done_pulse;
    movx_done |=> !movx_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done");

  // ===========================================
  // processor clock phase: low at the wrap, high right after
  property p_clk_phase;
    processor_tick |-> !processor_clock ##1 processor_clock;
  endproperty
  a_clk_phase: assert property (p_clk_phase) else $error("clk phase");

  // main scenarios seen
  c_adc: cover property (adc_wr_ack);
  c_rmw: cover property (movx_done && ram_we);
  c_tick: cover property (processor_tick);
endmodule

bind mcd_top mcd_top_chk #(.BASE_HIGH(BASE_HIGH), .BASE_MID(BASE_MID),
  .BASE_LOW(BASE_LOW)) u_chk (.*);

// file: verif/tb_mpu_clock_and_memory_decode.sv
// self-checking bench for the processor clock and memory decode block
// assumes mcd_ram_model as shared RAM and the checker bound to uut
module tb_mpu_clock_and_memory_decode;
  timeunit 1ns;
  timeprecision 1ps;
  // ===========================================
  // signals
  logic clk, arst_n, master_clk_range_high, master_clk_range_mid;
  logic prog_req, mem_req, mem_we, mem_indirect, bit_we, bit_wdata;
  logic dptr_load, dptr_inc, movx_req, movx_write, movx_use_dptr;
  logic movx_ri_sel, adc_wr_req, processor_clock, processor_tick;
  logic flash_req, bit_rdata, movx_done, adc_wr_ack, ram_re, ram_we;
  logic [2:0]  cpu_clock_divider, irq_index, reg_sel;
  logic [3:0]  adc_frame_divider, adc_wr_word;
  logic [6:0]  bit_addr;
  logic [7:0]  mem_addr, mem_wdata, mem_rdata, reg_addr, movx_wdata;
  logic [7:0]  movx_rdata;
  logic [9:0]  ram_addr;
  logic [15:0] prog_addr, reset_vector, irq_vector, dptr_wdata, dptr_value;
  logic [17:0] flash_addr;
  logic [31:0] adc_wr_data, ram_wdata, ram_rdata;
  logic [17:0] rows [0:15];
  int          miscompares, n_compared, cycles, c;

  mcd_top uut (.*);
  mcd_ram_model u_ram (.*);

  always #4 clk = ~clk;
  // cut a hung run short
  always @(posedge clk) begin
    cycles++;
    if (cycles > 40000) begin
      miscompares++;
      complete_run();
    end
  end

  // ===========================================
  // shared tasks
  task automatic complete_run();
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic mem_op(input logic w, i, input logic [7:0] a, d);
    {mem_req, mem_we, mem_indirect, mem_addr, mem_wdata} = {1'b1, w, i, a, d};
    step();
    mem_req = 0;
    step();
  endtask
  task automatic fetch(input logic [15:0] a, input logic [17:0] exp);
    prog_req = 1;
    prog_addr = a;
    step();
    chk(flash_addr, exp);
    chk(flash_req, 1);
    prog_req = 0;
    step();
  endtask
  task automatic dp(input logic ld, inc, input logic [15:0] v);
    {dptr_load, dptr_inc, dptr_wdata} = {ld, inc, v};
    step();
    {dptr_load, dptr_inc} = 2'h0;
    step();
  endtask
  // one external move; latency counted in clock edges
  task automatic movx(input logic w, p, r, input logic [7:0] d, input int l);
    int n;
    {movx_req, movx_write, movx_use_dptr, movx_ri_sel} = {1'b1, w, p, r};
    movx_wdata = d;
    n = 0;
    do begin
      step();
      n++;
    end while (!movx_done && n < 20);
    movx_req = 0;
    chk(n, l);
    step();
  endtask
  task automatic tick_gap();
    c = 0;
    do begin
      step();
      c++;
    end while (!processor_tick && c < 600);
  endtask

  // ===========================================
  // main sequence
  initial begin
    {clk, arst_n, master_clk_range_high, master_clk_range_mid, prog_req} = '0;
    {mem_req, mem_we, mem_indirect, bit_we, bit_wdata, dptr_load} = '0;
    {dptr_inc, movx_req, movx_write, movx_use_dptr, movx_ri_sel} = '0;
    {adc_wr_req, cpu_clock_divider, irq_index, reg_sel, bit_addr} = '0;
    {adc_frame_divider, adc_wr_word, mem_addr, mem_wdata} = '0;
    {movx_wdata, prog_addr, dptr_wdata, adc_wr_data} = '0;
    rows = '{18'h2053C, 18'h1053C, 18'h37FA5, 18'h07FA5, 18'h2B6FD,
      18'h3B677, 18'h0B605, 18'h1B677, 18'h2995A, 18'h09900, 18'h2BF20,
      18'h0BF20, 18'h2D008, 18'h09200, 18'h20840, 18'h209C3};
    repeat (16) @(posedge clk);
    #1 arst_n = 1;
    // table of internal memory and register accesses
    for (int i = 0; i < 16; i++) begin
      mem_op(rows[i][17], rows[i][16], rows[i][15:8], rows[i][7:0]);
      if (!rows[i][17]) chk(mem_rdata, rows[i][7:0]);
    end
    reg_sel = 3'h3;
    #1 chk(reg_addr, 8'h0B);
    chk(reset_vector, 16'h0000);
    for (int n = 0; n < 8; n++) begin
      irq_index = n[2:0];
      #1 chk(irq_vector, 16'h0003 + 16'(n * 8));
    end
    fetch(16'h8123, 18'h28123);
    fetch(16'h7FFF, 18'h07FFF);
    fetch(16'hFFFF, 18'h2FFFF);
    // bit area maps onto byte 0x21
    mem_op(1, 0, 8'h21, 8'h00);
    {bit_we, bit_addr, bit_wdata} = {1'b1, 7'h0A, 1'b1};
    step();
    bit_we = 0;
    step();
    chk(bit_rdata, 1);
    mem_op(0, 0, 8'h21, 8'h00);
    chk(mem_rdata, 8'h04);
    // paged moves into configuration, battery and unmapped space
    movx(1, 0, 0, 8'h99, 1);
    movx(0, 0, 0, 8'h00, 1);
    chk(movx_rdata, 8'h99);
    movx(1, 0, 1, 8'h3E, 1);
    movx(0, 0, 1, 8'h00, 1);
    chk(movx_rdata, 8'h3E);
    mem_op(1, 0, 8'hBF, 8'h30);
    movx(1, 0, 0, 8'h11, 1);
    movx(0, 0, 0, 8'h00, 1);
    chk(movx_rdata, 8'h00);
    // dual pointers and byte merge in shared RAM
    dp(1, 0, 16'h0105);
    chk(dptr_value, 16'h0105);
    mem_op(1, 0, 8'h92, 8'h01);
    chk(dptr_value, 16'h0000);
    dp(1, 0, 16'h0FFF);
    movx(1, 1, 0, 8'h5A, 3);
    mem_op(1, 0, 8'h92, 8'h00);
    chk(dptr_value, 16'h0105);
    dp(0, 1, 16'h0000);
    chk(dptr_value, 16'h0106);
    movx(1, 1, 0, 8'hC3, 3);
    dp(0, 1, 16'h0000);
    movx(1, 1, 0, 8'h11, 3);
    dp(1, 0, 16'h0106);
    movx(0, 1, 0, 8'h00, 3);
    chk(movx_rdata, 8'hC3);
    mem_op(1, 0, 8'h92, 8'h01);
    movx(0, 1, 0, 8'h00, 3);
    chk(movx_rdata, 8'h5A);
    // converter writes blocked at divider zero, then let through
    {adc_wr_req, adc_wr_word, adc_wr_data} = {1'b1, 4'h2, 32'hDEADBEEF};
    repeat (4) begin
      step();
      chk(adc_wr_ack, 0);
    end
    adc_frame_divider = 4'h1;
    #1 chk(adc_wr_ack, 1);
    step();
    {adc_wr_req, adc_frame_divider} = 5'h00;
    dp(1, 0, 16'h0009);
    movx(0, 1, 0, 8'h00, 3);
    chk(movx_rdata, 8'hBE);
    // pointer bytes through direct register writes and reads
    mem_op(1, 0, 8'h85, 8'h12);
    chk(dptr_value, 16'h1209);
    mem_op(0, 0, 8'h83, 8'h00);
    chk(mem_rdata, 8'h01);
    // processor clock period per range and divider code
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 3; k++) begin
        master_clk_range_high = (r == 0);
        master_clk_range_mid = (r == 1);
        cpu_clock_divider = (k == 2) ? 3'h7 : 3'(3 * k);
        tick_gap();
        tick_gap();
        tick_gap();
        chk(c, (r + 2) << ((k == 2) ? 6 : 3 * k));
        chk(processor_clock, 0);
        step();
        chk(processor_clock, 1);
      end
    end
    // second reset in mid-run clears the bank
    arst_n = 0;
    step();
    arst_n = 1;
    mem_op(0, 0, 8'hB6, 8'h00);
    chk(mem_rdata, 8'h00);
    fetch(16'h8001, 18'h00001);
    complete_run();
  end
endmodule
